/* File: ffr_top.sv */
// Flag response configuration: two setup registers, overvoltage debounce,
// accurate overcurrent delay, restart wait and soft start blanking.
// Assumes flags arrive synchronous to core_clk; per-flag action codes come
// from outside as a packed pair of bits per flag.
`timescale 1ns/100ps
module ffr_top (
  // Clock, reset, enable
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                ce,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  output logic [7:0]               reg_rdata,
  // Protection flags
  input  wire logic                supply_overvoltage_flag,
  input  wire logic                core_supply_overvoltage_flag,
  input  wire ffr_pkg::ffr_flags_t flags_in,
  input  wire logic [13:0]         action_codes,
  input  wire logic [6:0]          resolve_cfg,
  input  wire logic                soft_start_active,
  input  wire logic                reload_done,
  // Power stage control
  output logic                     first_sync_rectifier_output_en,
  output logic                     second_sync_rectifier_output_en,
  output logic                     oring_switch_en,
  output logic                     pwm_en,
  output logic                     eeprom_reload_req,
  output logic                     shutdown_active
);
  //////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] setup_r, setup_nxt;
  logic [7:0] blank_r, blank_nxt;

  always_comb begin
    setup_nxt = setup_r;
    blank_nxt = blank_r;
    if (reg_wr && reg_addr == ffr_pkg::ADDR_SETUP) begin
      setup_nxt = reg_wdata;
    end
    if (reg_wr && reg_addr == ffr_pkg::ADDR_BLANK) begin
      blank_nxt = reg_wdata;
    end
  end

  logic [7:0] rdata_nxt;
  always_comb begin
    unique case (reg_addr)
      ffr_pkg::ADDR_SETUP: rdata_nxt = setup_r;
      ffr_pkg::ADDR_BLANK: rdata_nxt = blank_r;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      setup_r   <= ffr_pkg::RST_SETUP;
      blank_r   <= ffr_pkg::RST_BLANK;
      reg_rdata <= 8'h00;
    end else if (ce) begin
      setup_r   <= setup_nxt;
      blank_r   <= blank_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Overvoltage debounce

  logic        ov_ignore;
  logic        ov_raw;
  logic [15:0] ov_cnt_r, ov_cnt_nxt;
  logic [15:0] ov_limit;
  logic        ov_trip;

  assign ov_ignore = setup_r[ffr_pkg::OV_IGNORE_BIT];
  // Ignore bit removes both flags before the timer can see them
  assign ov_raw = (supply_overvoltage_flag | core_supply_overvoltage_flag)
                  & ~ov_ignore;
  assign ov_limit = setup_r[ffr_pkg::OV_DEBOUNCE_BIT]
                  ? 16'(ffr_pkg::OV_DEB_LONG_CYC)
                  : 16'(ffr_pkg::OV_DEB_SHORT_CYC);

  always_comb begin
    ov_cnt_nxt = 16'h0000;
    if (ov_raw && ov_cnt_r < ov_limit) begin
      ov_cnt_nxt = ov_cnt_r + 16'h0001;
    end else if (ov_raw) begin
      ov_cnt_nxt = ov_cnt_r;
    end
  end
  assign ov_trip = ov_raw && ov_cnt_r >= ov_limit;

  //////////////////////////////////////////////////////////////////////////
  // Blanking and accurate overcurrent delay

  ffr_pkg::ffr_flags_t seen;
  ffr_blank u_blank (
    .blank_cfg         (blank_r),
    .soft_start_active (soft_start_active),
    .raw               (flags_in),
    .seen              (seen)
  );

  logic [6:0]  seen_v;
  logic        oc_acc;
  logic        oc_acc_q;
  logic        oc_done;
  logic        oc_fired_r, oc_fired_nxt;
  logic [15:0] oc_ticks;
  assign seen_v = seen;
  assign oc_acc = seen.oc_acc_pri | seen.oc_acc_sec;

  always_comb begin
    unique case (setup_r[ffr_pkg::OC_DELAY_HI:ffr_pkg::OC_DELAY_LO])
      3'h0: oc_ticks = 16'(ffr_pkg::OC_D0_100US);
      3'h1: oc_ticks = 16'(ffr_pkg::OC_D1_100US);
      3'h2: oc_ticks = 16'(ffr_pkg::OC_D2_100US);
      3'h3: oc_ticks = 16'(ffr_pkg::OC_D3_100US);
      3'h4: oc_ticks = 16'(ffr_pkg::OC_D4_100US);
      3'h5: oc_ticks = 16'(ffr_pkg::OC_D5_100US);
      3'h6: oc_ticks = 16'(ffr_pkg::OC_D6_100US);
      3'h7: oc_ticks = 16'(ffr_pkg::OC_D7_100US);
    endcase
  end

  ffr_timer u_oc_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ce       (ce),
    .start    (oc_acc & ~oc_acc_q),
    .stop     (~oc_acc),
    .ticks    (oc_ticks),
    .prescale (16'(ffr_pkg::CYC_PER_100US)),
    .done     (oc_done)
  );

  always_comb begin
    oc_fired_nxt = oc_fired_r;
    if (!oc_acc) begin
      oc_fired_nxt = 1'b0;
    end else if (oc_done) begin
      oc_fired_nxt = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-flag action decode

  logic [6:0] active;
  logic       want_sr_off, want_or_off, want_all_off;
  logic       want_latch;
  always_comb begin
    active = seen_v;
    // Accurate overcurrent only acts after its delay
    active[1] = seen_v[1] & oc_fired_r;
    active[2] = seen_v[2] & oc_fired_r;
    want_sr_off  = 1'b0;
    want_or_off  = 1'b0;
    want_all_off = 1'b0;
    want_latch   = 1'b0;
    for (int k = 0; k < 7; k++) begin
      if (active[k]) begin
        unique case (action_codes[2*k +: 2])
          ffr_pkg::ACT_IGNORE:  ;
          ffr_pkg::ACT_SR_OFF:  want_sr_off = 1'b1;
          ffr_pkg::ACT_OR_OFF:  want_or_off = 1'b1;
          ffr_pkg::ACT_ALL_OFF: begin
            want_all_off = 1'b1;
            want_latch   = want_latch | resolve_cfg[k];
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shutdown and restart sequencing

  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,
    ST_DOWN   = 4'h2,
    ST_WAIT   = 4'h4,
    ST_RELOAD = 4'h8
  } ffr_state_t;

  ffr_state_t  st_r, st_nxt;
  logic        ov_cause_r, ov_cause_nxt;
  logic        latched_r, latched_nxt;
  logic        rs_start;
  logic        rs_done;
  logic [15:0] rs_ticks;

  always_comb begin
    unique case (setup_r[ffr_pkg::RESTART_HI:ffr_pkg::RESTART_LO])
      2'h0: rs_ticks = 16'(ffr_pkg::RS_D0_100US);
      2'h1: rs_ticks = 16'(ffr_pkg::RS_D1_100US);
      2'h2: rs_ticks = 16'(ffr_pkg::RS_D2_100US);
      2'h3: rs_ticks = 16'(ffr_pkg::RS_D3_100US);
    endcase
  end

  always_comb begin
    st_nxt       = st_r;
    ov_cause_nxt = ov_cause_r;
    latched_nxt  = latched_r;
    rs_start     = 1'b0;
    unique case (st_r)
      ST_RUN: begin
        if (ov_trip || want_all_off) begin
          st_nxt       = ST_DOWN;
          ov_cause_nxt = ov_trip;
          latched_nxt  = want_latch;
        end
      end
      ST_DOWN: begin
        // Wait for every cause to clear; latched faults need a power cycle
        if (!ov_raw && !want_all_off && !latched_r) begin
          st_nxt   = ST_WAIT;
          rs_start = 1'b1;
        end
      end
      ST_WAIT: begin
        if (ov_trip || want_all_off) begin
          // A new cause during the wait keeps its reload and latch demands
          st_nxt       = ST_DOWN;
          ov_cause_nxt = ov_cause_r | ov_trip;
          latched_nxt  = latched_r | want_latch;
        end else if (rs_done) begin
          st_nxt = (ov_cause_r && setup_r[ffr_pkg::OV_RELOAD_BIT])
                 ? ST_RELOAD : ST_RUN;
        end
      end
      ST_RELOAD: begin
        if (reload_done) begin
          st_nxt       = ST_RUN;
          ov_cause_nxt = 1'b0;
        end
      end
      default: st_nxt = ST_DOWN;
    endcase
  end

  ffr_timer u_rs_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ce       (ce),
    .start    (rs_start),
    // Stop must not swallow the start pulse issued while leaving ST_DOWN
    .stop     (st_nxt == ST_DOWN),
    .ticks    (rs_ticks),
    .prescale (16'(ffr_pkg::CYC_PER_100US)),
    .done     (rs_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Output registers

  ffr_pkg::ffr_ctrl_t ctrl_nxt;
  always_comb begin
    // Next state, so pwm drops on the same edge as shutdown_active rises
    ctrl_nxt.pwm_en     = (st_nxt == ST_RUN) && !want_all_off;
    ctrl_nxt.oring_en   = ctrl_nxt.pwm_en && !want_or_off;
    ctrl_nxt.sr_en      = ctrl_nxt.pwm_en && !want_sr_off
                        && !(blank_r[ffr_pkg::BLANK_SR_BIT]
                             && soft_start_active);
    ctrl_nxt.reload_req = st_nxt == ST_RELOAD;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ov_cnt_r   <= 16'h0000;
      oc_acc_q   <= 1'b0;
      oc_fired_r <= 1'b0;
      st_r       <= ST_RUN;
      ov_cause_r <= 1'b0;
      latched_r  <= 1'b0;
      first_sync_rectifier_output_en  <= 1'b0;
      second_sync_rectifier_output_en <= 1'b0;
      oring_switch_en   <= 1'b0;
      pwm_en            <= 1'b0;
      eeprom_reload_req <= 1'b0;
      shutdown_active   <= 1'b0;
    end else if (ce) begin
      ov_cnt_r   <= ov_cnt_nxt;
      oc_acc_q   <= oc_acc;
      oc_fired_r <= oc_fired_nxt;
      st_r       <= st_nxt;
      ov_cause_r <= ov_cause_nxt;
      latched_r  <= latched_nxt;
      first_sync_rectifier_output_en  <= ctrl_nxt.sr_en;
      second_sync_rectifier_output_en <= ctrl_nxt.sr_en;
      oring_switch_en   <= ctrl_nxt.oring_en;
      pwm_en            <= ctrl_nxt.pwm_en;
      eeprom_reload_req <= ctrl_nxt.reload_req;
      shutdown_active   <= st_nxt != ST_RUN;
    end
  end
endmodule // ffr_top

/* File: ffr_pkg.sv */
// Constants, field layout and carrier types for the flag response block.
// Assumes a 100 MHz core clock and an 8-bit register port from the host.
//
// Overview of operation
// - Overvoltage-ignore bit set: both supply overvoltage flags disregarded.
// - After overvoltage shutdown, reload bit 1 reloads before restart.
// - Overvoltage debounce is 500 us when debounce bit is 1, 2 us when 0.
// - Accurate overcurrent action waits a delay chosen by field [4:2].
// - Restart after shutdown waits 0.5, 1, 2 or 4 s chosen by field [1:0].
// - Rectifier-blank bit holds both rectifier outputs off in soft start.
// - Blanking bit 6 hides the overtemperature flag during soft start.
// - Blanking bit 5 hides the external fault input during soft start.
// - Blanking bit 4 hides the local overvoltage flag during soft start.
// - Blanking bit 3 hides the load overvoltage flag during soft start.
// - Blanking bit 2 hides secondary accurate overcurrent in soft start.
// - Blanking bit 1 hides primary accurate overcurrent in soft start.
// - Blanking bit 0 hides the primary fast overcurrent flag in soft start.
// - Resolve setting 0 re-enables after the fault clears and restart delay.
// - Action code: 00 ignore, 01 rectifiers off, 10 oring off, 11 all off.
package ffr_pkg;

  localparam logic [7:0] ADDR_SETUP = 8'h0e;
  localparam logic [7:0] ADDR_BLANK = 8'h0f;
  localparam logic [7:0] RST_SETUP  = 8'h00;
  localparam logic [7:0] RST_BLANK  = 8'h00;

  // Setup register fields
  localparam int OV_IGNORE_BIT   = 7;
  localparam int OV_RELOAD_BIT   = 6;
  localparam int OV_DEBOUNCE_BIT = 5;
  localparam int OC_DELAY_HI     = 4;
  localparam int OC_DELAY_LO     = 2;
  localparam int RESTART_HI      = 1;
  localparam int RESTART_LO      = 0;
  // Blanking register bit 7 gates the rectifiers
  localparam int BLANK_SR_BIT    = 7;

  // Times in their own units, counts derived at 100 MHz
  localparam int CLK_MHZ         = 100;
  localparam int OV_DEB_LONG_US  = 500;
  localparam int OV_DEB_SHORT_US = 2;
  localparam int OV_DEB_LONG_CYC  = OV_DEB_LONG_US * CLK_MHZ;
  localparam int OV_DEB_SHORT_CYC = OV_DEB_SHORT_US * CLK_MHZ;
  localparam int CYC_PER_100US   = 100 * CLK_MHZ;
  // Overcurrent delays in units of 100 us: 1.3ms .. 2.6s
  localparam int OC_D0_100US = 13;
  localparam int OC_D1_100US = 130;
  localparam int OC_D2_100US = 1300;
  localparam int OC_D3_100US = 2600;
  localparam int OC_D4_100US = 6000;
  localparam int OC_D5_100US = 13000;
  localparam int OC_D6_100US = 20000;
  localparam int OC_D7_100US = 26000;
  // Restart delays in units of 100 us: 0.5, 1, 2, 4 s
  localparam int RS_D0_100US = 5000;
  localparam int RS_D1_100US = 10000;
  localparam int RS_D2_100US = 20000;
  localparam int RS_D3_100US = 40000;

  // Action codes
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_SR_OFF = 2'h1;
  localparam logic [1:0] ACT_OR_OFF = 2'h2;
  localparam logic [1:0] ACT_ALL_OFF = 2'h3;

  // Raw protection flags, bit order matches blanking bits 0..6
  typedef struct packed {
    logic otp;
    logic ext_fault;
    logic local_ov;
    logic load_ov;
    logic oc_acc_sec;
    logic oc_acc_pri;
    logic oc_fast_pri;
  } ffr_flags_t;

  // Outputs toward the power stage
  typedef struct packed {
    logic sr_en;
    logic oring_en;
    logic pwm_en;
    logic reload_req;
  } ffr_ctrl_t;

endpackage

/* File: ffr_timer.sv */
// Down counter in 100 us ticks, used for the long programmable waits.
// Assumes the caller holds start for one cycle; ce freezes it.
`timescale 1ns/100ps
module ffr_timer (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Control
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [15:0] ticks,
  input  wire logic [15:0] prescale,
  // Status
  output logic             done
);
  logic [15:0] tick_r, tick_nxt;
  logic [15:0] pre_r, pre_nxt;
  logic        run_r, run_nxt;
  logic        done_nxt;

  always_comb begin
    tick_nxt = tick_r;
    pre_nxt  = pre_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (stop) begin
      run_nxt = 1'b0;
    end else if (start) begin
      run_nxt  = 1'b1;
      tick_nxt = ticks;
      pre_nxt  = prescale;
    end else if (run_r) begin
      if (pre_r > 16'h0001) begin
        pre_nxt = pre_r - 16'h0001;
      end else begin
        pre_nxt = prescale;
        if (tick_r <= 16'h0001) begin
          run_nxt  = 1'b0;
          done_nxt = 1'b1;
        end else begin
          tick_nxt = tick_r - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tick_r <= 16'h0000;
      pre_r  <= 16'h0000;
      run_r  <= 1'b0;
      done   <= 1'b0;
    end else if (ce) begin
      tick_r <= tick_nxt;
      pre_r  <= pre_nxt;
      run_r  <= run_nxt;
      done   <= done_nxt;
    end
  end
endmodule // ffr_timer

/* File: ffr_blank.sv */
// Soft start blanking of the raw protection flags, one gate per bit.
// Assumes soft_start_active is high for the whole ramp.
`timescale 1ns/100ps
module ffr_blank (
  // Inputs
  input  wire logic [7:0]        blank_cfg,
  input  wire logic              soft_start_active,
  input  wire ffr_pkg::ffr_flags_t raw,
  // Result
  output ffr_pkg::ffr_flags_t    seen
);
  logic [6:0] raw_v;
  logic [6:0] seen_v;
  assign raw_v = raw;

  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_blank
      // Bits 0..6 map to fast oc, pri oc, sec oc, load ov, local ov, ext, otp
      assign seen_v[i] = raw_v[i]
                       & ~(blank_cfg[i] & soft_start_active);
    end
  endgenerate

  assign seen = seen_v;
endmodule // ffr_blank

/* File: ffr_monitor.sv */
// Checker for the flag response block, bound to the top module's ports.
// Assumes ce is held high; both registers are shadowed from port writes.
`timescale 1ns/100ps
module ffr_monitor (
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                resetn,
  input wire logic                ce,
  // Register port
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_wr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  // Flags
  input wire logic                supply_overvoltage_flag,
  input wire logic                core_supply_overvoltage_flag,
  input wire ffr_pkg::ffr_flags_t flags_in,
  input wire logic [13:0]         action_codes,
  input wire logic                soft_start_active,
  // Power stage
  input wire logic                first_sync_rectifier_output_en,
  input wire logic                second_sync_rectifier_output_en,
  input wire logic                oring_switch_en,
  input wire logic                pwm_en,
  input wire logic                shutdown_active
);
  logic [7:0]  setup_r, setup_nxt, blank_r, blank_nxt;
  logic [15:0] hold_r, hold_nxt, run_r, run_nxt;
  logic [6:0]  vis;
  logic        ov_seen;
  logic        quiet;

  always_comb begin
    setup_nxt = setup_r;
    blank_nxt = blank_r;
    if (ce && reg_wr && reg_addr == ffr_pkg::ADDR_SETUP) setup_nxt = reg_wdata;
    if (ce && reg_wr && reg_addr == ffr_pkg::ADDR_BLANK) blank_nxt = reg_wdata;
    ov_seen = (supply_overvoltage_flag || core_supply_overvoltage_flag)
              && !setup_r[7];
    vis = flags_in & ~(soft_start_active ? blank_r[6:0] : 7'h00);
    quiet = (vis == 7'h00) && !ov_seen;
    // Hold counts raw overvoltage; run counts it only while still running
    hold_nxt = ov_seen ? hold_r + 16'h1 : 16'h0;
    run_nxt = (ov_seen && pwm_en) ? run_r + 16'h1 : 16'h0;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      setup_r <= 8'h00;
      blank_r <= 8'h00;
      hold_r  <= 16'h0;
      run_r   <= 16'h0;
    end else begin
      setup_r <= setup_nxt;
      blank_r <= blank_nxt;
      hold_r  <= hold_nxt;
      run_r   <= run_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence wr_then_hold;
    ce && reg_wr && (reg_addr == 8'h0e || reg_addr == 8'h0f)
    ##1 !reg_wr && reg_addr == $past(reg_addr);
  endsequence

  a_reg_read_back: assert property (
    wr_then_hold |=> reg_rdata == $past(reg_wdata, 2))
    else $error("register read back differs");
  a_unmapped_zero: assert property (
    ce && reg_addr != 8'h0e && reg_addr != 8'h0f |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_quiet_keeps_on: assert property (
    quiet && $past(quiet) && pwm_en |=> pwm_en)
    else $error("supply stopped without a visible cause");
  a_ov_short_early: assert property (
    !setup_r[5] && run_r == 16'd150 && vis == 7'h00 |=> pwm_en)
    else $error("short debounce tripped early");
  a_ov_long_early: assert property (
    setup_r[5] && run_r == 16'd1000 && vis == 7'h00 |=> pwm_en)
    else $error("long debounce tripped early");
  a_ov_short_trip: assert property (
    !setup_r[5] && hold_r == 16'd210 |-> !pwm_en && shutdown_active)
    else $error("short debounce did not trip");
  a_ov_long_trip: assert property (
    setup_r[5] && hold_r == 16'd50010 |-> !pwm_en && shutdown_active)
    else $error("long debounce did not trip");
  a_sr_blank_hold: assert property (
    blank_r[7] && soft_start_active |=> !first_sync_rectifier_output_en
    && !second_sync_rectifier_output_en)
    else $error("rectifier enabled in soft start");
  a_act_all_off: assert property (
    vis[0] && action_codes[1:0] == 2'h3 |-> ##[1:2] !pwm_en && !oring_switch_en)
    else $error("full shutdown action missing");
  a_act_sr_off: assert property (
    vis[0] && action_codes[1:0] == 2'h1 |-> ##[1:2]
    !first_sync_rectifier_output_en && !second_sync_rectifier_output_en)
    else $error("rectifier off action missing");
  a_act_or_off: assert property (
    vis[0] && action_codes[1:0] == 2'h2 |-> ##[1:2] !oring_switch_en)
    else $error("oring off action missing");
endmodule // ffr_monitor

bind ffr_top ffr_monitor u_mon (.core_clk, .resetn, .ce, .reg_addr,
  .reg_wr, .reg_wdata, .reg_rdata, .supply_overvoltage_flag,
  .core_supply_overvoltage_flag, .flags_in, .action_codes,
  .soft_start_active, .first_sync_rectifier_output_en,
  .second_sync_rectifier_output_en, .oring_switch_en, .pwm_en,
  .shutdown_active);

/* File: fault_flag_response_config_test.sv */
// Self-checking bench for the flag response block.
// Assumes the design's fixed 100 MHz counts; the long waits are not run.
`timescale 1ns/100ps
module fault_flag_response_config_test;
  logic                core_clk, resetn, ce, reg_wr, reload_done;
  logic [7:0]          reg_addr, reg_wdata, reg_rdata;
  logic [1:0]          ov_in;
  ffr_pkg::ffr_flags_t flags_in;
  logic [13:0]         action_codes;
  logic [6:0]          resolve_cfg;
  logic                soft_start_active, sr1, sr2, oring, pwm, reload, shut;
  int                  n_mismatch = 0;
  int                  samples_checked = 0;

  ffr_top u_dut (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .supply_overvoltage_flag(ov_in[0]),
    .core_supply_overvoltage_flag(ov_in[1]), .flags_in(flags_in),
    .action_codes(action_codes), .resolve_cfg(resolve_cfg),
    .soft_start_active(soft_start_active), .reload_done(reload_done),
    .first_sync_rectifier_output_en(sr1),
    .second_sync_rectifier_output_en(sr2), .oring_switch_en(oring),
    .pwm_en(pwm), .eeprom_reload_req(reload), .shutdown_active(shut));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    tick(2);
    chk(reg_rdata, exp);
  endtask

  // Every scenario starts from reset: a shutdown needs seconds to clear
  task automatic do_reset();
    @(posedge core_clk);
    resetn            <= 1'b0;
    ov_in             <= 2'h0;
    flags_in          <= ffr_pkg::ffr_flags_t'(7'h00);
    action_codes      <= 14'h0000;
    soft_start_active <= 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    tick(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    do_reset();
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'h00);
    wr(8'h0e, 8'ha5);
    wr(8'h0f, 8'h5a);
    rd(8'h0e, 8'ha5);
    rd(8'h0f, 8'h5a);
    rd(8'h10, 8'h00);
    // A write while ce is low must not land
    @(posedge core_clk);
    ce <= 1'b0;
    wr(8'h0e, 8'h11);
    @(posedge core_clk);
    ce <= 1'b1;
    rd(8'h0e, 8'ha5);
    $display("t_regs done");
  endtask

  task automatic t_ov(input logic [7:0] cfg, input logic [1:0] sel,
                      input int hold, input logic run);
    do_reset();
    wr(8'h0e, cfg);
    @(posedge core_clk);
    ov_in <= sel;
    tick(hold);
    chk({5'h00, reload, pwm, shut}, {5'h00, 1'b0, run, !run});
    @(posedge core_clk);
    ov_in <= 2'h0;
    $display("t_ov done");
  endtask

  task automatic t_act(input logic [1:0] code);
    logic s;
    s = (code == 2'h0 || code == 2'h2);
    do_reset();
    @(posedge core_clk);
    action_codes <= {12'h000, code};
    flags_in     <= ffr_pkg::ffr_flags_t'(7'h01);
    tick(4);
    chk({4'h0, sr1, sr2, oring, pwm},
        {4'h0, s, s, code < 2'h2, code != 2'h3});
    $display("t_act done");
  endtask

  task automatic t_blank();
    do_reset();
    wr(8'h0f, 8'hff);
    @(posedge core_clk);
    soft_start_active <= 1'b1;
    action_codes      <= 14'h3fff;
    flags_in          <= ffr_pkg::ffr_flags_t'(7'h7f);
    tick(5);
    chk({4'h0, sr1, sr2, oring, pwm}, 8'h03);
    @(posedge core_clk);
    soft_start_active <= 1'b0;
    tick(4);
    chk({6'h00, oring, pwm}, 8'h00);
    $display("t_blank done");
  endtask

  // One blanking bit set must hide its own flag
  task automatic t_blank_bit(input int b);
    do_reset();
    wr(8'h0f, 8'h01 << b);
    @(posedge core_clk);
    soft_start_active <= 1'b1;
    action_codes      <= 14'h3fff;
    flags_in          <= ffr_pkg::ffr_flags_t'(7'h01 << b);
    tick(4);
    chk({5'h00, sr1, oring, pwm}, 8'h07);
    $display("t_blank_bit done");
  endtask

  // Accurate overcurrent must not act well before its shortest delay
  task automatic t_oc_early();
    do_reset();
    @(posedge core_clk);
    action_codes <= 14'h3fff;
    flags_in     <= ffr_pkg::ffr_flags_t'(7'h06);
    tick(2000);
    chk({6'h00, pwm, shut}, 8'h02);
    $display("t_oc_early done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn            = 1'b0;
    ce                = 1'b1;
    reg_addr          = 8'h00;
    reg_wr            = 1'b0;
    reg_wdata         = 8'h00;
    ov_in             = 2'h0;
    flags_in          = ffr_pkg::ffr_flags_t'(7'h00);
    action_codes      = 14'h0000;
    resolve_cfg       = 7'h00;
    soft_start_active = 1'b0;
    reload_done       = 1'b0;
    t_regs();
    t_ov(8'h80, 2'h3, 400, 1'b1);
    t_ov(8'h00, 2'h1, 190, 1'b1);
    t_ov(8'h00, 2'h2, 215, 1'b0);
    t_ov(8'h20, 2'h1, 600, 1'b1);
    t_ov(8'h20, 2'h2, 50020, 1'b0);
    for (int c = 0; c < 4; c++)
      t_act(2'(c));
    t_blank();
    for (int b = 0; b < 7; b++)
      t_blank_bit(b);
    t_oc_early();
    end_of_test();
  end

  // Whole run is about 55k cycles
  initial begin
    repeat (80000) @(posedge core_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule // fault_flag_response_config_test
